// ---- src/pmc_pkg.sv ----
package pmc_pkg;
  localparam int WB_AW = 6;
  localparam int PWR_W = 9;
  localparam int GATE_W = 16;
  localparam int DIV_W = 8;
  localparam int PLL_W = 7;
  localparam int NPER = 4;
  // Register byte offsets
  localparam logic [WB_AW-1:0] OFS_PCTRL = 6'h00;
  localparam logic [WB_AW-1:0] OFS_RUNCFG = 6'h04;
  localparam logic [WB_AW-1:0] OFS_SLPCFG = 6'h08;
  localparam logic [WB_AW-1:0] OFS_GATE = 6'h0C;
  localparam logic [WB_AW-1:0] OFS_SYSDIV = 6'h10;
  localparam logic [WB_AW-1:0] OFS_PLL = 6'h14;
  localparam logic [WB_AW-1:0] OFS_CLKSEL = 6'h18;
  localparam logic [WB_AW-1:0] OFS_PDIV0 = 6'h1C;
  localparam logic [WB_AW-1:0] OFS_STATUS = 6'h2C;
  // Power enable bit positions, 1 = powered
  localparam int B_IRC_OUT = 0;
  localparam int B_IRC = 1;
  localparam int B_FLASH = 2;
  localparam int B_BOD = 3;
  localparam int B_ADC = 4;
  localparam int B_SYSTEM_OSC = 5;
  localparam int B_WATCHDOG_OSC = 6;
  localparam int B_PLL = 7;
  localparam int B_USB = 8;
  // Reset values
  localparam logic [PWR_W-1:0] RUNCFG_RST = 9'h00F;
  localparam logic [PWR_W-1:0] SLPCFG_RST = 9'h000;
  localparam logic [GATE_W-1:0] GATE_RST = 16'h00FF;
  localparam logic [DIV_W-1:0] SYSDIV_RST = 8'h01;
  localparam logic [PLL_W-1:0] PLL_RST = 7'h00;
  localparam logic [DIV_W-1:0] PDIV_RST = 8'h00;
  // Power-mode field values
  localparam logic [1:0] PM_SLEEP = 2'h0;
  localparam logic [1:0] PM_DEEP = 2'h1;
  localparam logic [1:0] PM_PDOWN = 2'h2;
  localparam logic [1:0] PM_DPD = 2'h3;
  // System clock sources
  localparam logic [1:0] CS_IRC = 2'h0;
  localparam logic [1:0] CS_SYSTEM_OSC = 2'h1;
  localparam logic [1:0] CS_WATCHDOG_OSC = 2'h2;
  typedef enum logic [2:0] {
    ST_ACTIVE = 3'h0,
    ST_SLEEP = 3'h1,
    ST_DEEP = 3'h3,
    ST_PDOWN = 3'h2,
    ST_DPD = 3'h6
  } pmc_state_t;
endpackage

// ---- src/pmc_power_mode_controller.sv ----
// Operation
// - Active plus Sleep, Deep-sleep, Power-down, Deep power-down, each with power states.
// - Deep-sleep: RC osc on, output off, flash on; rest off; BROWNOUT_DETECTOR, WD osc configurable.
// - Power-down: RC osc, output, flash off; deep power-down all off; Sleep keeps config.
// - Locked watchdog on RC osc forces RC osc and output on in Deep-sleep and Power-down.
// - Locked watchdog source keeps running in Deep-sleep and Power-down, overriding sleep config.
// - Debug is unavailable in every reduced power mode.
// - After reset Active mode with reset values of run config and clock gates.
// - Active: core and memories on system clock, peripherals on system or own clock.
// - Run power config controls each analog block and flash in Active and Sleep only.
// - System clock from RC osc by default, system osc or watchdog osc; PLL and divider.
// - Serial, sync serial, USB, clock output each have a divider; zero stops clock.
// - Sleep stops core clock until interrupt or reset; system clock keeps running.
// - Gated-on peripherals keep running in Sleep and may wake the core.
// - Sleep retains all state and holds pin levels static.
// - Sleep ends on an enabled interrupt reaching the core or any reset.
// - Interrupt wake restores run config and dividers; reset wake gives defaults.
`timescale 1ns/1ps
`default_nettype none
module pmc_power_mode_controller
  import pmc_pkg::*;
(
  input wire logic CORE_CLK_I,
  input wire logic SYS_RST_I,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [pmc_pkg::WB_AW-1:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic WFI_REQ_I,
  input wire logic DEEP_SLEEP_SEL_I,
  input wire logic IRQ_WAKE_I,
  input wire logic WDT_LOCK_I,
  input wire logic WDT_SRC_IRC_I,
  output logic CORE_CLK_EN_O,
  output logic DEBUG_EN_O,
  output logic PIN_HOLD_O,
  output logic [2:0] MODE_O,
  output logic [pmc_pkg::PWR_W-1:0] PWR_EN_O,
  output logic [pmc_pkg::GATE_W-1:0] BUS_CLK_EN_O,
  output logic [1:0] SYS_CLK_SEL_O,
  output logic [pmc_pkg::DIV_W-1:0] SYS_CLK_DIV_O,
  output logic [pmc_pkg::PLL_W-1:0] PLL_CTRL_O,
  output logic [pmc_pkg::NPER-1:0] PER_CLK_EN_O,
  output logic [pmc_pkg::NPER*pmc_pkg::DIV_W-1:0] PER_CLK_DIV_O
);
  import pmc_pkg::*;

  // ==========================================================
  // Register bus
  pmc_state_t state;
  pmc_state_t next_state;
  logic [1:0] power_mode_field;
  logic [PWR_W-1:0] run_power_config;
  logic [PWR_W-1:0] sleep_power_config;
  logic [GATE_W-1:0] bus_clock_gate_ctrl;
  logic [DIV_W-1:0] system_clock_divider;
  logic [PLL_W-1:0] pll_control;
  logic [1:0] clk_sel;
  logic [DIV_W-1:0] per_div [NPER];
  logic [31:0] next_rdata;
  logic wr;
  logic run_like;
  // Byte distance between neighbouring peripheral divider registers
  localparam int PDIV_STEP = 4;

  assign wr = WB_CYC_I && WB_STB_I && WB_WE_I && WB_ACK_O;

  always_ff @(posedge CORE_CLK_I)
  begin
    if (SYS_RST_I || WB_ACK_O)
      WB_ACK_O <= 1'b0;
    else
      WB_ACK_O <= WB_CYC_I && WB_STB_I;
  end

  always_comb
  begin
    next_rdata = 32'h0000_0000;
    unique case (WB_ADR_I)
      OFS_PCTRL: next_rdata[1:0] = power_mode_field;
      OFS_RUNCFG: next_rdata[PWR_W-1:0] = run_power_config;
      OFS_SLPCFG: next_rdata[PWR_W-1:0] = sleep_power_config;
      OFS_GATE: next_rdata[GATE_W-1:0] = bus_clock_gate_ctrl;
      OFS_SYSDIV: next_rdata[DIV_W-1:0] = system_clock_divider;
      OFS_PLL: next_rdata[PLL_W-1:0] = pll_control;
      OFS_CLKSEL: next_rdata[1:0] = clk_sel;
      OFS_STATUS: next_rdata[2:0] = state;
      default:
      begin
        for (int i = 0; i < NPER; i++)
          if (WB_ADR_I == OFS_PDIV0 + 6'(PDIV_STEP * i))
            next_rdata[DIV_W-1:0] = per_div[i];
      end
    endcase
  end

  always_ff @(posedge CORE_CLK_I)
  begin
    if (SYS_RST_I)
      WB_DAT_O <= 32'h0000_0000;
    else if (WB_CYC_I && WB_STB_I && !WB_WE_I && !WB_ACK_O)
      WB_DAT_O <= next_rdata;
  end

  // ==========================================================
  // Configuration registers, reset to Active defaults
  always_ff @(posedge CORE_CLK_I)
  begin
    if (SYS_RST_I)
    begin
      power_mode_field <= PM_SLEEP;
      run_power_config <= RUNCFG_RST;
      sleep_power_config <= SLPCFG_RST;
      bus_clock_gate_ctrl <= GATE_RST;
      system_clock_divider <= SYSDIV_RST;
      pll_control <= PLL_RST;
      clk_sel <= CS_IRC;
    end
    else if (wr && WB_SEL_I[0])
    begin
      unique case (WB_ADR_I)
        OFS_PCTRL: power_mode_field <= WB_DAT_I[1:0];
        OFS_RUNCFG: run_power_config <= WB_DAT_I[PWR_W-1:0];
        OFS_SLPCFG: sleep_power_config <= WB_DAT_I[PWR_W-1:0];
        OFS_GATE: bus_clock_gate_ctrl <= WB_DAT_I[GATE_W-1:0];
        OFS_SYSDIV: system_clock_divider <= WB_DAT_I[DIV_W-1:0];
        OFS_PLL: pll_control <= WB_DAT_I[PLL_W-1:0];
        OFS_CLKSEL: clk_sel <= (WB_DAT_I[1:0] == PM_DPD) ? clk_sel : WB_DAT_I[1:0];
        default:
        begin
        end
      endcase
    end
  end

  always_ff @(posedge CORE_CLK_I)
  begin
    for (int i = 0; i < NPER; i++)
    begin
      if (SYS_RST_I)
        per_div[i] <= PDIV_RST;
      else if (wr && WB_SEL_I[0] && WB_ADR_I == OFS_PDIV0 + 6'(PDIV_STEP * i))
        per_div[i] <= WB_DAT_I[DIV_W-1:0];
    end
  end

  // ==========================================================
  // Mode sequencer
  always_comb
  begin
    next_state = state;
    unique case (state)
      ST_ACTIVE:
        if (WFI_REQ_I)
        begin
          if (!DEEP_SLEEP_SEL_I || power_mode_field == PM_SLEEP)
            next_state = ST_SLEEP;
          else if (power_mode_field == PM_DEEP)
            next_state = ST_DEEP;
          else if (power_mode_field == PM_PDOWN)
            next_state = ST_PDOWN;
          else
            next_state = ST_DPD;
        end
      ST_SLEEP, ST_DEEP, ST_PDOWN:
        if (IRQ_WAKE_I)
          next_state = ST_ACTIVE;
      ST_DPD:
        next_state = ST_DPD;
      default:
        next_state = ST_ACTIVE;
    endcase
  end

  always_ff @(posedge CORE_CLK_I)
  begin
    if (SYS_RST_I)
      state <= ST_ACTIVE;
    else
      state <= next_state;
  end

  // ==========================================================
  // Power and clock outputs
  logic wdt_irc_lock;
  logic wdt_osc_lock;
  logic [PWR_W-1:0] next_pwr;

  assign wdt_irc_lock = WDT_LOCK_I && WDT_SRC_IRC_I;
  assign wdt_osc_lock = WDT_LOCK_I && !WDT_SRC_IRC_I;
  assign run_like = (next_state == ST_ACTIVE) || (next_state == ST_SLEEP);

  always_comb
  begin
    next_pwr = '0;
    unique case (next_state)
      ST_ACTIVE, ST_SLEEP:
        next_pwr = run_power_config;
      ST_DEEP:
      begin
        next_pwr[B_IRC] = 1'b1;
        next_pwr[B_IRC_OUT] = wdt_irc_lock;
        next_pwr[B_FLASH] = 1'b1;
        next_pwr[B_BOD] = sleep_power_config[B_BOD];
        next_pwr[B_WATCHDOG_OSC] = sleep_power_config[B_WATCHDOG_OSC] || wdt_osc_lock;
      end
      ST_PDOWN:
      begin
        next_pwr[B_IRC] = wdt_irc_lock;
        next_pwr[B_IRC_OUT] = wdt_irc_lock;
        next_pwr[B_BOD] = sleep_power_config[B_BOD];
        next_pwr[B_WATCHDOG_OSC] = sleep_power_config[B_WATCHDOG_OSC] || wdt_osc_lock;
      end
      default:
        next_pwr = '0;
    endcase
  end

  always_ff @(posedge CORE_CLK_I)
  begin
    if (SYS_RST_I)
    begin
      PWR_EN_O <= RUNCFG_RST;
      BUS_CLK_EN_O <= GATE_RST;
      MODE_O <= ST_ACTIVE;
    end
    else
    begin
      PWR_EN_O <= next_pwr;
      BUS_CLK_EN_O <= run_like ? bus_clock_gate_ctrl : '0;
      MODE_O <= next_state;
    end
  end

  always_ff @(posedge CORE_CLK_I)
  begin
    if (SYS_RST_I)
    begin
      CORE_CLK_EN_O <= 1'b1;
      DEBUG_EN_O <= 1'b1;
      PIN_HOLD_O <= 1'b0;
    end
    else
    begin
      CORE_CLK_EN_O <= next_state == ST_ACTIVE;
      DEBUG_EN_O <= next_state == ST_ACTIVE;
      PIN_HOLD_O <= next_state != ST_ACTIVE;
    end
  end

  always_ff @(posedge CORE_CLK_I)
  begin
    if (SYS_RST_I)
    begin
      SYS_CLK_SEL_O <= CS_IRC;
      SYS_CLK_DIV_O <= SYSDIV_RST;
      PLL_CTRL_O <= PLL_RST;
    end
    else
    begin
      SYS_CLK_SEL_O <= clk_sel;
      SYS_CLK_DIV_O <= run_like ? system_clock_divider : '0;
      PLL_CTRL_O <= pll_control;
    end
  end

  always_ff @(posedge CORE_CLK_I)
  begin
    for (int i = 0; i < NPER; i++)
    begin
      if (SYS_RST_I)
      begin
        PER_CLK_EN_O[i] <= 1'b0;
        PER_CLK_DIV_O[i*DIV_W +: DIV_W] <= PDIV_RST;
      end
      else
      begin
        PER_CLK_EN_O[i] <= run_like && (per_div[i] != PDIV_RST);
        PER_CLK_DIV_O[i*DIV_W +: DIV_W] <= per_div[i];
      end
    end
  end

  // ==========================================================
  // Checks
  a_reset_active: assert property (@(posedge CORE_CLK_I) SYS_RST_I |=> MODE_O == ST_ACTIVE && CORE_CLK_EN_O)
    else $error("not active after reset");
  a_sleep_entry: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    state == ST_ACTIVE && WFI_REQ_I && !DEEP_SLEEP_SEL_I |=> MODE_O == ST_SLEEP && !CORE_CLK_EN_O)
    else $error("sleep not entered");
  a_deep_select: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    state == ST_ACTIVE && WFI_REQ_I && DEEP_SLEEP_SEL_I && power_mode_field == PM_PDOWN
    |=> MODE_O == ST_PDOWN)
    else $error("wrong deep mode");
  a_irq_wake: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    state inside {ST_SLEEP, ST_DEEP, ST_PDOWN} && IRQ_WAKE_I |=> CORE_CLK_EN_O && DEBUG_EN_O)
    else $error("no wake on interrupt");
  a_deep_power: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    MODE_O == ST_DEEP |-> PWR_EN_O[B_IRC] && PWR_EN_O[B_FLASH] && !PWR_EN_O[B_PLL]
    && !PWR_EN_O[B_ADC] && !PWR_EN_O[B_USB] && BUS_CLK_EN_O == '0)
    else $error("deep-sleep power wrong");
  a_pdown_power: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    MODE_O == ST_PDOWN && !WDT_LOCK_I && $stable(WDT_LOCK_I) |-> !PWR_EN_O[B_IRC] && !PWR_EN_O[B_FLASH])
    else $error("power-down power wrong");
  a_irc_lock: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    next_state == ST_DEEP && wdt_irc_lock |=> PWR_EN_O[B_IRC] && PWR_EN_O[B_IRC_OUT])
    else $error("locked rc osc not forced");
  a_watchdog_osc_lock: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    next_state == ST_PDOWN && wdt_osc_lock |=> PWR_EN_O[B_WATCHDOG_OSC])
    else $error("locked wd osc not kept");
  a_debug_off: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    MODE_O != ST_ACTIVE |-> !DEBUG_EN_O && PIN_HOLD_O)
    else $error("debug on in low power");
  a_sleep_cfg: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    MODE_O == ST_SLEEP && $past(next_state) == ST_SLEEP |-> PWR_EN_O == $past(run_power_config))
    else $error("sleep config not kept");
endmodule
`default_nettype wire

// ---- sim/pmc_core_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module pmc_core_model
(
  input wire logic clk_i,
  input wire logic core_clk_en_i,
  output logic wfi_o,
  output logic deep_sel_o,
  output logic irq_o
);
  initial
  begin
    wfi_o = 1'b0;
    deep_sel_o = 1'b0;
    irq_o = 1'b0;
  end
  // ==========
  // Sleep request
  // Select bit goes out with the wait pulse; a stopped core still sets the select bit but issues no wait pulse
  task automatic sleep(input logic deep);
    @(posedge clk_i);
    deep_sel_o <= deep;
    wfi_o <= core_clk_en_i;
    @(posedge clk_i);
    wfi_o <= 1'b0;
  endtask
  // ==========
  // Wake interrupt
  // Held until the core clock returns, bounded for modes that never wake
  task automatic wake();
    int n;
    @(posedge clk_i);
    irq_o <= 1'b1;
    for (n = 0; n < 8 && core_clk_en_i !== 1'b1; n++)
      @(posedge clk_i);
    irq_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- sim/pmc_power_mode_controller_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin miscompares++; $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module pmc_power_mode_controller_tb;
  import pmc_pkg::*;
  logic clk, rst, cyc, stb, we, lock, src, ack, cke, dbg, hold, wait_for_interrupt_instr, dsel, irq;
  logic [WB_AW-1:0] adr;
  logic [3:0] sel;
  logic [3:0] bsel;
  logic [31:0] wdat, rdat, q;
  logic [2:0] mode;
  logic [PWR_W-1:0] pwr;
  logic [GATE_W-1:0] gate;
  logic [1:0] csel;
  logic [DIV_W-1:0] sdiv;
  logic [PLL_W-1:0] pll;
  logic [NPER-1:0] pen;
  logic [NPER*DIV_W-1:0] pdiv;
  int miscompares = 0;
  int n_compared = 0;
  pmc_power_mode_controller i_pmc_power_mode_controller (.CORE_CLK_I(clk), .SYS_RST_I(rst), .WB_CYC_I(cyc),
    .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
    .WB_ACK_O(ack), .WFI_REQ_I(wait_for_interrupt_instr), .DEEP_SLEEP_SEL_I(dsel), .IRQ_WAKE_I(irq), .WDT_LOCK_I(lock),
    .WDT_SRC_IRC_I(src), .CORE_CLK_EN_O(cke), .DEBUG_EN_O(dbg), .PIN_HOLD_O(hold), .MODE_O(mode),
    .PWR_EN_O(pwr), .BUS_CLK_EN_O(gate), .SYS_CLK_SEL_O(csel), .SYS_CLK_DIV_O(sdiv), .PLL_CTRL_O(pll),
    .PER_CLK_EN_O(pen), .PER_CLK_DIV_O(pdiv));
  pmc_core_model i_pmc_core_model (.clk_i(clk), .core_clk_en_i(cke), .wfi_o(wait_for_interrupt_instr), .deep_sel_o(dsel), .irq_o(irq));
  // ==========
  // Bus and check tasks
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [WB_AW-1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= bsel;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 20)
    begin
      miscompares++;
      end_sim();
    end
  endtask
  task automatic rdc(input logic [WB_AW-1:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    `CHK("read", e, q)
  endtask
  task automatic chk_rst();
    @(negedge clk);
    `CHK("mode", ST_ACTIVE, mode)
    `CHK("cke", 1'b1, cke)
    `CHK("dbg", 1'b1, dbg)
    `CHK("pwr", RUNCFG_RST, pwr)
    `CHK("gate", GATE_RST, gate)
    `CHK("csel", CS_IRC, csel)
    `CHK("sdiv", SYSDIV_RST, sdiv)
    rdc(OFS_RUNCFG, {23'h0, RUNCFG_RST});
  endtask
  // Enter a reduced mode, check it, then wake and check the restore
  task automatic go(input logic [1:0] pm, input logic ds, input logic [8:0] sc, input logic lk, input logic si,
                    input logic [2:0] em, input logic [PWR_W-1:0] ep);
    wb(1'b1, OFS_PCTRL, {30'h0, pm});
    wb(1'b1, OFS_SLPCFG, {23'h0, sc});
    lock <= lk;
    src <= si;
    i_pmc_core_model.sleep(ds);
    @(negedge clk);
    `CHK("mode", em, mode)
    `CHK("pwr", ep, pwr)
    `CHK("cke", 1'b0, cke)
    `CHK("dbg", 1'b0, dbg)
    `CHK("hold", 1'b1, hold)
    `CHK("gate", (em == ST_SLEEP) ? 16'h1234 : 16'h0, gate)
    `CHK("spen", (em == ST_SLEEP) ? 4'h7 : 4'h0, pen)
    `CHK("ssdiv", (em == ST_SLEEP) ? 8'h03 : 8'h0, sdiv)
    rdc(OFS_STATUS, {29'h0, em});
    i_pmc_core_model.wake();
    @(negedge clk);
    `CHK("wake", (em == ST_DPD) ? ST_DPD : ST_ACTIVE, mode)
    `CHK("rest", (em == ST_DPD) ? 9'h0 : 9'h1A5, pwr)
    `CHK("rdiv", (em == ST_DPD) ? 8'h0 : 8'h03, sdiv)
  endtask
  // ==========
  // Clock and main sequence
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial
  begin
    rst = 1'b1;
    {cyc, stb, we, lock, src} = 5'h00;
    adr = 6'h00;
    sel = 4'hF;
    bsel = 4'hF;
    wdat = 32'h0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    chk_rst();
    wb(1'b1, OFS_RUNCFG, 32'h0000_01A5);
    wb(1'b1, OFS_GATE, 32'h0000_1234);
    wb(1'b1, OFS_SYSDIV, 32'h0000_0003);
    wb(1'b1, OFS_PLL, 32'h0000_0025);
    repeat (2) @(negedge clk);
    `CHK("pwr", 9'h1A5, pwr)
    `CHK("gate", 16'h1234, gate)
    `CHK("sdiv", 8'h03, sdiv)
    `CHK("pll", 7'h25, pll)
    rdc(OFS_GATE, 32'h0000_1234);
    rdc(OFS_PLL, 32'h0000_0025);
    // Writes without byte lane 0 and writes to status must be ignored
    bsel = 4'hE;
    wb(1'b1, OFS_SYSDIV, 32'h0000_0077);
    bsel = 4'hF;
    rdc(OFS_SYSDIV, 32'h0000_0003);
    wb(1'b1, OFS_STATUS, 32'h0000_0005);
    rdc(OFS_STATUS, 32'h0000_0000);
    for (int i = 0; i < 4; i++)
    begin
      wb(1'b1, OFS_CLKSEL, 32'(i));
      repeat (2) @(negedge clk);
      `CHK("csel", 2'((i < 3) ? i : 2), csel)
      wb(1'b1, OFS_PDIV0 + 6'(4 * i), 32'(i + 1));
      repeat (2) @(negedge clk);
      `CHK("pdiv", 8'(i + 1), pdiv[8*i +: 8])
      `CHK("pen", 1'b1, pen[i])
    end
    wb(1'b1, OFS_PDIV0 + 6'h0C, 32'h0);
    repeat (2) @(negedge clk);
    `CHK("pstop", 1'b0, pen[3])
    rdc(6'h30, 32'h0);
    go(PM_SLEEP, 1'b0, 9'h000, 1'b0, 1'b0, ST_SLEEP, 9'h1A5);
    go(PM_DEEP, 1'b0, 9'h048, 1'b0, 1'b0, ST_SLEEP, 9'h1A5);
    go(PM_SLEEP, 1'b1, 9'h048, 1'b0, 1'b0, ST_SLEEP, 9'h1A5);
    go(PM_DEEP, 1'b1, 9'h048, 1'b0, 1'b0, ST_DEEP, 9'h04E);
    go(PM_DEEP, 1'b1, 9'h000, 1'b1, 1'b1, ST_DEEP, 9'h007);
    go(PM_DEEP, 1'b1, 9'h000, 1'b1, 1'b0, ST_DEEP, 9'h046);
    go(PM_PDOWN, 1'b1, 9'h008, 1'b0, 1'b0, ST_PDOWN, 9'h008);
    go(PM_PDOWN, 1'b1, 9'h000, 1'b1, 1'b0, ST_PDOWN, 9'h040);
    go(PM_PDOWN, 1'b1, 9'h048, 1'b1, 1'b1, ST_PDOWN, 9'h04B);
    go(PM_DPD, 1'b1, 9'h048, 1'b1, 1'b1, ST_DPD, 9'h000);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    chk_rst();
    end_sim();
  end
endmodule
`undef CHK
`default_nettype wire
